// File: charger_status_event_flags.sv
// Functional notes
// - status bit 0 follows sensor open level
// - status at 0x2, read-only, upper bits reserved
// - charge flags at 0x3, reset zero, clear on read
// - fault flags at 0x4, reset zero, clear on read
// - open flag at 0x5, bit 0 latches open
// - bit 6 latches taper entry until read
// - bit 5 latches charge termination
// - bit 4 latches input current limit engagement
// - bit 3 latches path management operation
// - bit 2 latches input voltage loop operation
// - bit 1 latches thermal regulation activation
// - bit 0 latches any input-good change
// - no input-good interrupt at low-battery power-up
// - fault bit 7 latches input overvoltage
// - fault bit 5 latches battery overcurrent
// - fault bit 4 zero means lockout detected
// - fault bits 3..0 latch cold/cool/warm/hot entry
// - set mask bit suppresses that event's interrupt
`include "charger_flags_regs.svh"
`timescale 1ns/100ps

module charger_status_event_flags
    import charger_flags_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic RD_STB,
    input wire logic [7:0] RD_ADDR,
    output logic [7:0] RD_DATA,
    input wire logic TAPER_ACTIVE,
    input wire logic TERMINATION_DONE,
    input wire logic INPUT_LIMIT_ACTIVE,
    input wire logic PATH_MGMT_ACTIVE,
    input wire logic INPUT_VLOOP_ACTIVE,
    input wire logic THERMAL_LOOP_ACTIVE,
    input wire logic INPUT_GOOD,
    input wire logic INPUT_OVERVOLTAGE,
    input wire logic BATTERY_OVERCURRENT,
    input wire logic BATTERY_BELOW_LOCKOUT,
    input wire logic COLD_REGION,
    input wire logic COOL_REGION,
    input wire logic WARM_REGION,
    input wire logic HOT_REGION,
    input wire logic SENSOR_OPEN_LEVEL,
    input wire logic [7:0] CHARGE_MASK,
    input wire logic [7:0] FAULT_MASK,
    input wire logic [7:0] OPEN_MASK,
    output logic IRQ_PULSE
);

    // ****************************************************************
    // condition vectors
    // ****************************************************************

    logic [7:0] charge_cond;
    logic [7:0] fault_cond;
    logic [7:0] charge_flag;
    logic [7:0] fault_flag;
    logic [7:0] charge_evt;
    logic [7:0] fault_evt;
    logic open_flag;
    logic open_evt;

    // gather the detector levels at their field positions
    always_comb begin
        charge_cond = 8'h00;
        charge_cond[`BIT_TAPER_ENTRY_EVENT] = TAPER_ACTIVE;
        charge_cond[`BIT_TERMINATION_EVENT] = TERMINATION_DONE;
        charge_cond[`BIT_INPUT_LIMIT_EVENT] = INPUT_LIMIT_ACTIVE;
        charge_cond[`BIT_PATH_REGULATION_EVENT] = PATH_MGMT_ACTIVE;
        charge_cond[`BIT_INPUT_VOLTAGE_LOOP_EVENT] = INPUT_VLOOP_ACTIVE;
        charge_cond[`BIT_THERMAL_LOOP_EVENT] = THERMAL_LOOP_ACTIVE;
        charge_cond[`BIT_INPUT_GOOD_CHANGE_EVENT] = INPUT_GOOD;
    end

    // fault side, reserved bit 6 never has a source
    always_comb begin
        fault_cond = 8'h00;
        fault_cond[`BIT_INPUT_OVERVOLTAGE_EVENT] = INPUT_OVERVOLTAGE;
        fault_cond[`BIT_BATTERY_OVERCURRENT_EVENT] =
            BATTERY_OVERCURRENT;
        fault_cond[`BIT_BATTERY_LOW_EVENT] = BATTERY_BELOW_LOCKOUT;
        fault_cond[`BIT_COLD_REGION_EVENT] = COLD_REGION;
        fault_cond[`BIT_COOL_REGION_EVENT] = COOL_REGION;
        fault_cond[`BIT_WARM_REGION_EVENT] = WARM_REGION;
        fault_cond[`BIT_HOT_REGION_EVENT] = HOT_REGION;
    end

    // ****************************************************************
    // read decode
    // ****************************************************************

    read_sel_t read_sel;
    logic clear_charge;
    logic clear_fault;
    logic clear_open;

    // one-hot select; anything outside the four addresses reads zero
    always_comb begin
        unique case (RD_ADDR)
            `ADDR_THERM_OPEN_STATUS: read_sel = SEL_STATUS;
            `ADDR_CHARGE_EVENT_FLAGS: read_sel = SEL_CHARGE;
            `ADDR_FAULT_EVENT_FLAGS: read_sel = SEL_FAULT;
            `ADDR_THERM_OPEN_EVENT_FLAGS: read_sel = SEL_OPEN;
            default: read_sel = SEL_NONE;
        endcase
    end

    // the read itself is the clear; the host must keep what it got
    always_comb begin
        clear_charge = RD_STB && (read_sel == SEL_CHARGE);
        clear_fault = RD_STB && (read_sel == SEL_FAULT);
        clear_open = RD_STB && (read_sel == SEL_OPEN);
    end

    // ****************************************************************
    // charge event flags
    // ****************************************************************

    genvar gi;
    generate
        for (gi = 0; gi < `CHARGE_FLAG_COUNT; gi = gi + 1) begin : g_charge
            // power-good change is the only field that fires on both edges
            event_latch #(
                .BOTH_EDGES(gi == `BIT_INPUT_GOOD_CHANGE_EVENT),
                .INVERT(1'b0)
            ) u_latch (
                .clk(CLK_SYS),
                .rst_n(RESET_N),
                .cond(charge_cond[gi]),
                .rd_clear(clear_charge),
                .flag(charge_flag[gi]),
                .event_pulse(charge_evt[gi])
            );
        end
    endgenerate

    // reserved bit 7 has no latch and reads zero
    assign charge_flag[7] = 1'b0;
    assign charge_evt[7] = 1'b0;

    // ****************************************************************
    // fault event flags
    // ****************************************************************

    generate
        for (gi = 0; gi < `FAULT_FLAG_COUNT; gi = gi + 1) begin : g_fault
            if (gi == `BIT_FAULT_RESERVED) begin : g_rsvd
                assign fault_flag[gi] = 1'b0;
                assign fault_evt[gi] = 1'b0;
            end else begin : g_live
                // battery low field keeps the inverted encoding
                event_latch #(
                    .BOTH_EDGES(1'b0),
                    .INVERT(gi == `BIT_BATTERY_LOW_EVENT)
                ) u_latch (
                    .clk(CLK_SYS),
                    .rst_n(RESET_N),
                    .cond(fault_cond[gi]),
                    .rd_clear(clear_fault),
                    .flag(fault_flag[gi]),
                    .event_pulse(fault_evt[gi])
                );
            end
        end
    endgenerate

    // ****************************************************************
    // thermistor open flag
    // ****************************************************************

    // latches a rise of the open level
    event_latch #(
        .BOTH_EDGES(1'b0),
        .INVERT(1'b0)
    ) u_open_latch (
        .clk(CLK_SYS),
        .rst_n(RESET_N),
        .cond(SENSOR_OPEN_LEVEL),
        .rd_clear(clear_open),
        .flag(open_flag),
        .event_pulse(open_evt)
    );

    // ****************************************************************
    // read data register
    // ****************************************************************

    logic [7:0] read_value;
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;

    // captures pre-clear contents, so an event in the read cycle shows
    // either now or on the next read, never neither
    always_comb begin
        read_value = `UNMAPPED_READ_VALUE;
        unique case (read_sel)
            SEL_STATUS: begin
                read_value[`BIT_SENSOR_OPEN_LEVEL] = SENSOR_OPEN_LEVEL;
            end
            SEL_CHARGE: begin
                read_value = charge_flag;
            end
            SEL_FAULT: begin
                read_value = fault_flag;
            end
            SEL_OPEN: begin
                read_value[`BIT_SENSOR_OPEN_EVENT] = open_flag;
            end
            SEL_NONE: begin
                read_value = `UNMAPPED_READ_VALUE;
            end
        endcase
        rd_data_next = rd_data_reg;
        if (RD_STB) begin
            rd_data_next = read_value;
        end
    end

    // data holds until the next read strobe
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            rd_data_reg <= `RST_READ_DATA;
        end else begin
            rd_data_reg <= rd_data_next;
        end
    end

    // the port shows the register, never the live select
    assign RD_DATA = rd_data_reg;

    // ****************************************************************
    // power-up tracking for the input-good interrupt
    // ****************************************************************

    startup_state_t startup_reg;
    startup_state_t startup_next;
    logic suppress_good_irq;

    // the first input-good change after reset is the power-up one; its
    // flag still latches, only the interrupt is held back on low battery
    always_comb begin
        startup_next = startup_reg;
        suppress_good_irq = 1'b0;
        unique case (startup_reg)
            ST_STARTUP: begin
                if (charge_evt[`BIT_INPUT_GOOD_CHANGE_EVENT]) begin
                    suppress_good_irq = BATTERY_BELOW_LOCKOUT;
                    startup_next = ST_RUN;
                end
            end
            ST_RUN: begin
                startup_next = ST_RUN;
            end
        endcase
    end

    // leaves the armed state once per reset, so only one change is spared
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            startup_reg <= ST_STARTUP;
        end else begin
            startup_reg <= startup_next;
        end
    end

    // ****************************************************************
    // interrupt request
    // ****************************************************************

    logic [7:0] charge_irq;
    logic [7:0] fault_irq;
    logic irq_reg;
    logic irq_next;

    // a mask bit of one blocks only its own event, the flag still sets
    always_comb begin
        charge_irq = charge_evt & ~CHARGE_MASK;
        fault_irq = fault_evt & ~FAULT_MASK;
        if (suppress_good_irq) begin
            charge_irq[`BIT_INPUT_GOOD_CHANGE_EVENT] = 1'b0;
        end
        irq_next = (|charge_irq) | (|fault_irq) |
            (open_evt & ~OPEN_MASK[`BIT_SENSOR_OPEN_EVENT]);
    end

    // registered so the pin driver sees a clean one-cycle pulse
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    assign IRQ_PULSE = irq_reg;

endmodule

// File: charger_flags_regs.svh
`ifndef CHARGER_FLAGS_REGS_SVH
`define CHARGER_FLAGS_REGS_SVH

// ****************************************************************
// register addresses on the core read port
// ****************************************************************
`define ADDR_THERM_OPEN_STATUS 8'h02
`define ADDR_CHARGE_EVENT_FLAGS 8'h03
`define ADDR_FAULT_EVENT_FLAGS 8'h04
`define ADDR_THERM_OPEN_EVENT_FLAGS 8'h05

// ****************************************************************
// reset values
// ****************************************************************
`define RST_CHARGE_EVENT_FLAGS 8'h00
`define RST_FAULT_EVENT_FLAGS 8'h00
`define RST_THERM_OPEN_EVENT_FLAGS 8'h00
`define RST_READ_DATA 8'h00
`define UNMAPPED_READ_VALUE 8'h00

// ****************************************************************
// thermistor status and thermistor-open flag fields
// ****************************************************************
`define BIT_SENSOR_OPEN_LEVEL 0
`define BIT_SENSOR_OPEN_EVENT 0

// ****************************************************************
// charge event flag fields (bit 7 reserved)
// ****************************************************************
`define BIT_TAPER_ENTRY_EVENT 6
`define BIT_TERMINATION_EVENT 5
`define BIT_INPUT_LIMIT_EVENT 4
`define BIT_PATH_REGULATION_EVENT 3
`define BIT_INPUT_VOLTAGE_LOOP_EVENT 2
`define BIT_THERMAL_LOOP_EVENT 1
`define BIT_INPUT_GOOD_CHANGE_EVENT 0
`define CHARGE_FLAG_COUNT 7

// ****************************************************************
// fault event flag fields (bit 6 reserved)
// ****************************************************************
`define BIT_INPUT_OVERVOLTAGE_EVENT 7
`define BIT_FAULT_RESERVED 6
`define BIT_BATTERY_OVERCURRENT_EVENT 5
`define BIT_BATTERY_LOW_EVENT 4
`define BIT_COLD_REGION_EVENT 3
`define BIT_COOL_REGION_EVENT 2
`define BIT_WARM_REGION_EVENT 1
`define BIT_HOT_REGION_EVENT 0
`define FAULT_FLAG_COUNT 8

`endif

// File: charger_flags_pkg.sv
package charger_flags_pkg;

    // start-up tracking for the input power-good interrupt
    typedef enum logic [1:0] {
        ST_STARTUP = 2'b01,
        ST_RUN = 2'b10
    } startup_state_t;

    // read address decode result
    typedef enum logic [4:0] {
        SEL_STATUS = 5'b00001,
        SEL_CHARGE = 5'b00010,
        SEL_FAULT = 5'b00100,
        SEL_OPEN = 5'b01000,
        SEL_NONE = 5'b10000
    } read_sel_t;

endpackage

// File: event_latch.sv
`timescale 1ns/100ps

module event_latch #(
    parameter bit BOTH_EDGES = 1'b0,
    parameter bit INVERT = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cond,
    input wire logic rd_clear,
    output logic flag,
    output logic event_pulse
);

    logic prev_reg;
    logic prev_next;
    logic held_reg;
    logic held_next;

    // ****************************************************************
    // edge detect and sticky hold
    // ****************************************************************

    // a level that stays high gives one event only, so a read clears it
    always_comb begin
        prev_next = cond;
        if (BOTH_EDGES) begin
            event_pulse = cond ^ prev_reg;
        end else begin
            event_pulse = cond & ~prev_reg;
        end
        held_next = held_reg;
        if (rd_clear) begin
            held_next = 1'b0;
        end
        // set after clear: an event in the read cycle survives
        if (event_pulse) begin
            held_next = 1'b1;
        end
    end

    // prev starts low so a condition present at power-up counts as entry
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_reg <= 1'b0;
            held_reg <= INVERT;
        end else begin
            prev_reg <= prev_next;
            held_reg <= held_next;
        end
    end

    // inverted fields show 0 while the event is held
    assign flag = held_reg ^ INVERT;

endmodule

// File: charger_flags_checker.sv
`timescale 1ns/100ps

module charger_flags_checker (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic RD_STB,
    input wire logic [7:0] RD_ADDR,
    input wire logic [7:0] RD_DATA,
    input wire logic TAPER_ACTIVE,
    input wire logic INPUT_GOOD,
    input wire logic BATTERY_BELOW_LOCKOUT,
    input wire logic SENSOR_OPEN_LEVEL,
    input wire logic [7:0] CHARGE_MASK,
    input wire logic [7:0] FAULT_MASK,
    input wire logic [7:0] OPEN_MASK,
    input wire logic IRQ_PULSE
);
    // one clock domain, so clock and reset are given once
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);

    // ****************
    // read port
    // ****************
    // status bit follows the open level seen at the strobe edge
    AST_STATUS_LIVE:
        assert property (RD_STB && RD_ADDR == 8'h02 |=>
            RD_DATA == {7'h00, $past(SENSOR_OPEN_LEVEL)})
        else $error("status read mismatch");
    AST_UNMAPPED:
        assert property (RD_STB && (RD_ADDR < 8'h02 || RD_ADDR > 8'h05)
            |=> RD_DATA == 8'h00)
        else $error("unmapped read not zero");
    AST_RESERVED:
        assert property (RD_STB |=> (RD_DATA &
            ($past(RD_ADDR) == 8'h03 ? 8'h80 :
            $past(RD_ADDR) == 8'h04 ? 8'h40 :
            $past(RD_ADDR) == 8'h05 ? 8'hfe : 8'h00)) == 8'h00)
        else $error("reserved bit set");

    // ****************
    // events
    // ****************
    // the first edge after reset is skipped: edge history starts low
    AST_TAPER_IRQ:
        assert property ($past(RESET_N) && $rose(TAPER_ACTIVE)
            && !CHARGE_MASK[6] |=> IRQ_PULSE)
        else $error("taper entry gave no irq");
    AST_GOOD_IRQ:
        assert property ($past(RESET_N) && $changed(INPUT_GOOD) &&
            !CHARGE_MASK[0] && !BATTERY_BELOW_LOCKOUT |=> IRQ_PULSE)
        else $error("input good change gave no irq");
    AST_LOW_BIT:
        assert property ($past(RESET_N) && $rose(BATTERY_BELOW_LOCKOUT)
            ##1 RD_STB && RD_ADDR == 8'h04 |=> !RD_DATA[4])
        else $error("battery low bit not zero");
    AST_MASKED:
        assert property (&CHARGE_MASK[6:0] && &FAULT_MASK && OPEN_MASK[0]
            |=> !IRQ_PULSE)
        else $error("irq despite full mask");
    AST_READ_RACE:
        assert property (RD_STB && RD_ADDR == 8'h05 && $past(RESET_N) &&
            $rose(SENSOR_OPEN_LEVEL) ##1 RD_STB && RD_ADDR == 8'h05
            |=> RD_DATA[0])
        else $error("event lost in clearing read");
    AST_READ_TWICE:
        assert property (RD_STB && RD_ADDR == 8'h05 && $past(RESET_N) &&
            !$rose(SENSOR_OPEN_LEVEL) ##1 RD_STB && RD_ADDR == 8'h05
            |=> RD_DATA == 8'h00)
        else $error("flag survived its read");
endmodule

bind charger_status_event_flags charger_flags_checker u_chk (
    .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .RD_STB(RD_STB),
    .RD_ADDR(RD_ADDR), .RD_DATA(RD_DATA), .TAPER_ACTIVE(TAPER_ACTIVE),
    .INPUT_GOOD(INPUT_GOOD), .BATTERY_BELOW_LOCKOUT(BATTERY_BELOW_LOCKOUT),
    .SENSOR_OPEN_LEVEL(SENSOR_OPEN_LEVEL), .CHARGE_MASK(CHARGE_MASK),
    .FAULT_MASK(FAULT_MASK), .OPEN_MASK(OPEN_MASK), .IRQ_PULSE(IRQ_PULSE));

// File: charger_flags_host.sv
`timescale 1ns/100ps

module charger_flags_host (
    input wire logic clk,
    output logic stb,
    output logic [7:0] addr,
    input wire logic [7:0] data
);
    initial begin
        stb = 1'b0;
        addr = 8'h00;
    end
    // strobe is left high so reads can run back to back; idle drops it
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        stb = 1'b1;
        addr = a;
        @(posedge clk);
        #1;
        d = data;
    endtask
    // address carries no meaning off strobe, so it is scrambled
    task automatic idle(input int n);
        stb = 1'b0;
        addr = ~addr;
        repeat (n) @(posedge clk);
        #1;
    endtask
endmodule

// File: tb_charger_status_event_flags.sv
`timescale 1ns/100ps

module tb_charger_status_event_flags;
    logic clk, rst_n, irq, mo, po, pg, oe, xi, rd, first;
    logic [14:0] cv;
    logic [7:0] cm, fm, om, d, mc, mf, xd, ce, fe, gm, f, pf;
    logic [5:0] c, pc;
    wire stb;
    wire [7:0] addr, data;
    int i, j, cyc = 0, failures = 0, checked = 0;
    logic [7:0] seq [7] = '{8'h05, 8'h05, 8'h05, 8'h03, 8'h03, 8'h04, 8'h04};

    charger_status_event_flags u_dut (
        .CLK_SYS(clk), .RESET_N(rst_n), .RD_STB(stb), .RD_ADDR(addr),
        .RD_DATA(data), .TAPER_ACTIVE(cv[0]), .TERMINATION_DONE(cv[1]),
        .INPUT_LIMIT_ACTIVE(cv[2]), .PATH_MGMT_ACTIVE(cv[3]),
        .INPUT_VLOOP_ACTIVE(cv[4]), .THERMAL_LOOP_ACTIVE(cv[5]),
        .INPUT_GOOD(cv[6]), .INPUT_OVERVOLTAGE(cv[7]),
        .BATTERY_OVERCURRENT(cv[8]), .BATTERY_BELOW_LOCKOUT(cv[9]),
        .COLD_REGION(cv[10]), .COOL_REGION(cv[11]), .WARM_REGION(cv[12]),
        .HOT_REGION(cv[13]), .SENSOR_OPEN_LEVEL(cv[14]),
        .CHARGE_MASK(cm), .FAULT_MASK(fm), .OPEN_MASK(om), .IRQ_PULSE(irq));
    charger_flags_host u_host (.clk(clk), .stb(stb), .addr(addr),
        .data(data));

    task bad(input string m);
        failures++;
        $display("BAD %0t %s", $time, m);
    endtask
    task results;
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ****************
    // reference model
    // ****************
    // events are entries of a level, input good any change, so the model keeps last levels
    always @(posedge clk) begin
        c = {cv[0], cv[1], cv[2], cv[3], cv[4], cv[5]};
        f = {cv[7], 1'b0, cv[8], cv[9], cv[10], cv[11], cv[12], cv[13]};
        ce = {1'b0, c & ~pc, cv[6] ^ pg};
        fe = f & ~pf;
        oe = cv[14] & ~po;
        if (!rst_n) begin
            mc = 8'h00; mf = 8'h00; mo = 1'b0; pc = 6'h00; pf = 8'h00;
            po = 1'b0; pg = 1'b0; first = 1'b1; xi = 1'b0; rd = 1'b0;
        end else begin
            gm = cm;
            if (first && ce[0] && cv[9])
                gm[0] = 1'b1;
            if (ce[0])
                first = 1'b0;
            xi = |(ce & ~gm) | |(fe & ~fm) | (oe & ~om[0]);
            case (addr)
                8'h02: xd = {7'h00, cv[14]};
                8'h03: xd = mc;
                8'h04: xd = mf;
                8'h05: xd = {7'h00, mo};
                default: xd = 8'h00;
            endcase
            rd = stb;
            if (stb && addr == 8'h03) mc = 8'h00;
            if (stb && addr == 8'h04) mf = 8'h10;
            if (stb && addr == 8'h05) mo = 1'b0;
            // a new event beats the clearing read
            mc = mc | ce;
            mf = (mf | (fe & 8'hef)) & ~(fe & 8'h10);
            mo = mo | oe;
            pc = c; pf = f; po = cv[14]; pg = cv[6];
        end
        #2;
        checked++;
        if (irq !== xi) bad("irq pulse wrong");
        if (rd) begin
            checked++;
            if (data !== xd) bad("read data wrong");
        end
    end

    // ****************
    // clock, timeout, sequence
    // ****************
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad("timeout");
            results;
        end
    end
    initial begin
        rst_n = 1'b0; cv = 15'h0000; cm = 8'h00; fm = 8'h00; om = 8'h00;
        void'($urandom(84));
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        for (i = 0; i < 8; i++) u_host.rd(8'(i), d);
        u_host.rd(8'hff, d);
        u_host.idle(1);
        $display("test reset_values done");
        // each level enters together with a read, then is read again
        for (i = 0; i < 15; i++) begin
            cv[i] = 1'b1;
            for (j = 0; j < 7; j++) u_host.rd(seq[j], d);
            u_host.idle(1);
            cv[i] = 1'b0;
            u_host.idle(2);
        end
        $display("test event_walk done");
        rst_n = 1'b0;
        u_host.idle(3);
        rst_n = 1'b1;
        u_host.idle(1);
        cv[9] = 1'b1;
        u_host.idle(1);
        cv[6] = 1'b1;
        u_host.rd(8'h04, d);
        u_host.rd(8'h03, d);
        cv[6] = 1'b0;
        u_host.idle(2);
        cv = 15'h0000;
        u_host.idle(2);
        // input good and low battery already high while reset is held;
        // the battery low mask keeps its own pulse off the irq line
        fm = 8'h10;
        cv[6] = 1'b1;
        cv[9] = 1'b1;
        rst_n = 1'b0;
        u_host.idle(2);
        rst_n = 1'b1;
        u_host.rd(8'h04, d);
        u_host.rd(8'h03, d);
        u_host.idle(1);
        $display("test power_up done");
        // sparse random toggles; the first stretch runs fully masked
        for (i = 0; i < 400; i++) begin
            cm = (i < 100) ? 8'hff : 8'($urandom);
            fm = (i < 100) ? 8'hff : 8'($urandom);
            om = (i < 100) ? 8'hff : 8'($urandom);
            cv = cv ^ (15'($urandom) & 15'($urandom) & 15'($urandom));
            if ($urandom % 2) u_host.rd(8'($urandom % 8), d);
            else u_host.idle(1);
        end
        u_host.idle(2);
        $display("test random done");
        results;
    end
endmodule
